// ==== inc/bbm_pkg.sv ====
// Purpose: Constants shared by the baseband modem control register bank.
// Assumes: 25 MHz core clock, 16-bit serial control frames, MSB first.
// Notes: Reserved addresses read as zero.
package bbm_pkg;
	// Register addresses.
	localparam logic [6:0] ADDR_RX_LEN_HI = 7'h05;
	localparam logic [6:0] ADDR_RX_LEN_LO = 7'h06;
	localparam logic [6:0] ADDR_RX_SERVICE = 7'h07;
	localparam logic [6:0] ADDR_TX_GAIN = 7'h11;
	localparam logic [6:0] ADDR_TX_DUR_HI = 7'h12;
	localparam logic [6:0] ADDR_TX_DUR_LO = 7'h13;
	localparam logic [6:0] ADDR_LOW_TRIM = 7'h14;
	localparam logic [6:0] ADDR_HIGH_TRIM = 7'h15;
	localparam logic [6:0] ADDR_OPTIONS_A = 7'h1C;
	localparam logic [6:0] ADDR_OPTIONS_B = 7'h1D;

	// Reset values.
	localparam logic [7:0] RESET_BYTE = 8'h00;

	// Field positions.
	localparam int TXG_CODE_LSB = 2;
	localparam int TXG_SCRAMBLE_BIT = 1;
	localparam int TXG_LEN_EXT_BIT = 0;
	localparam int SVC_LEN_EXT_BIT = 7;
	localparam int SVC_MOD_SEL_BIT = 3;
	localparam int SVC_CLK_LOCK_BIT = 2;
	localparam int TRIM_MSB = 5;
	localparam int HGT_CH14_BIT = 7;
	localparam int HGT_PAD_BIT = 6;
	localparam int OPA_SAT_SIGN_BIT = 7;
	localparam int OPA_SAT_MAG_MSB = 6;
	localparam int OPA_SAT_MAG_LSB = 5;
	localparam int OPA_RETRIG_BIT = 4;
	localparam int OPA_ALT_BUS_BIT = 3;
	localparam int OPB_LNA_HOLD_BIT = 7;
	localparam int OPB_RETRIG_LOW_BIT = 2;

	// Write masks; reserved bits are not stored.
	localparam logic [7:0] MASK_LOW_TRIM = 8'h3F;
	localparam logic [7:0] MASK_OPTIONS_A = 8'hF8;
	localparam logic [7:0] MASK_OPTIONS_B = 8'h84;

	// Saturation threshold base.
	localparam logic [2:0] SAT_BASE = 3'h4;

	// Serial frame layout.
	localparam logic [4:0] FRAME_ADDR_BITS = 5'h08;
	localparam logic [4:0] FRAME_BITS = 5'h10;

	// Timing.
	localparam int CLK_FREQ_HZ = 25_000_000;
	localparam int CYCLES_PER_US = CLK_FREQ_HZ / 1_000_000;
	localparam int STEP_HOLD_BASE_US = 1;
	localparam int STEP_HOLD_TOTAL_US = 2;
	localparam logic [4:0] US_DIV_LAST = 5'(CYCLES_PER_US - 1);
	localparam logic [5:0] HOLD_BASE_CYC = 6'(STEP_HOLD_BASE_US * CYCLES_PER_US);
	localparam logic [5:0] HOLD_TOTAL_CYC = 6'(STEP_HOLD_TOTAL_US * CYCLES_PER_US);

	// Serial port phases.
	typedef enum logic [1:0]
	{
		BBM_PH_IDLE = 2'b00,
		BBM_PH_ADDR = 2'b01,
		BBM_PH_DATA = 2'b10
	} bbm_phase_e;
endpackage : bbm_pkg

// ==== hw/bbm_regs.sv ====
// Purpose: Control register bank of a spread-spectrum baseband modem.
// Assumes: Serial port pins are synchronous to core_clk and slower than it.
// Notes: Frame is R/W bit, 7-bit address, 8 data bits, MSB first.
// Operation
// - Received length high byte readable at 0x05.
// - Received DSSS length is packet microseconds.
// - Received length low byte readable at 0x06.
// - Service byte readable, bit 7 length extension.
// - Service bit 3 modulation select, zero CCK.
// - Service bit 2 shows synth clock lock.
// - Six-bit transmit gain code, bits 7..2.
// - Gain bit 1 set bypasses scrambler.
// - Gain bit 0 is transmitted length extension.
// - Transmit for programmed microseconds after request.
// - Six-bit low gain trim, bits 7..6 reserved.
// - Six-bit high gain trim in bits 5..0.
// - High trim bit 7 enables channel-14 filter.
// - High trim bit 6 enables Ds_attenuation_pad.
// - Saturation threshold is four plus signed offset.
// - Options A bit 4 enables saturation retrigger.
// - Options A bit 3 selects alternate bus.
// - LNA falling edge holds AGC 2us when enabled.
// - Options B bit 2 selects low retrigger count.
module bbm_regs
	import bbm_pkg::*;
(
	// Clock and reset.
	input wire logic core_clk,
	input wire logic sys_rst,
	// Serial control port.
	input wire logic port_sclk,
	input wire logic port_sel_n,
	input wire logic port_mosi,
	output logic port_miso,
	// Received header from the demodulator.
	input wire logic rx_header_valid,
	input wire logic [15:0] received_length_bits,
	input wire logic [7:0] received_service_bits,
	// Transmit control.
	input wire logic tx_start,
	output logic tx_active,
	output logic [5:0] transmit_gain_code,
	output logic scrambler_bypass,
	output logic transmit_length_extension,
	// Gain calibration and filtering.
	output logic [5:0] low_gain_offset,
	output logic [5:0] high_gain_offset,
	output logic ch14_filter_enable,
	output logic ds_attenuation_pad,
	// Automatic gain control options.
	input wire logic lna_gain_select_pin,
	output logic [2:0] saturation_threshold,
	output logic agc_retrigger_enable,
	output logic alt_data_bus_enable,
	output logic agc_retrigger_low,
	output logic agc_decision_hold
);
	import bbm_pkg::*;

	typedef struct packed
	{
		// Serial port framing.
		bbm_phase_e phase;
		logic sclk_prev;
		logic [4:0] bit_cnt;
		logic [7:0] shift_in;
		logic read_op;
		logic [6:0] addr;
		logic [7:0] shift_out;
		logic miso;

		// Register contents.
		logic [7:0] rx_len_hi;
		logic [7:0] rx_len_lo;
		logic [7:0] rx_service;
		logic [7:0] tx_gain;
		logic [7:0] tx_dur_hi;
		logic [7:0] tx_dur_lo;
		logic [7:0] low_trim;
		logic [7:0] high_trim;
		logic [7:0] options_a;
		logic [7:0] options_b;

		// Timers and derived outputs.
		logic [2:0] sat_thr;
		logic tx_busy;
		logic [15:0] us_left;
		logic [4:0] us_div;
		logic lna_prev;
		logic [5:0] hold_cnt;
		logic hold;
	} bbm_state_s;

	localparam bbm_state_s STATE_RESET = '{
		phase: BBM_PH_IDLE,
		sclk_prev: 1'b0,
		bit_cnt: 5'h00,
		shift_in: RESET_BYTE,
		read_op: 1'b0,
		addr: 7'h00,
		shift_out: RESET_BYTE,
		miso: 1'b0,

		rx_len_hi: RESET_BYTE,
		rx_len_lo: RESET_BYTE,
		rx_service: RESET_BYTE,
		tx_gain: RESET_BYTE,
		tx_dur_hi: RESET_BYTE,
		tx_dur_lo: RESET_BYTE,
		low_trim: RESET_BYTE,
		high_trim: RESET_BYTE,
		options_a: RESET_BYTE,
		options_b: RESET_BYTE,

		sat_thr: SAT_BASE,
		tx_busy: 1'b0,
		us_left: 16'h0000,
		us_div: 5'h00,
		lna_prev: 1'b0,
		hold_cnt: 6'h00,
		hold: 1'b0
	};

	bbm_state_s state_reg;
	bbm_state_s state_next;

	// Returns the readable value of one address.
	function automatic logic [7:0] read_byte(input bbm_state_s s, input logic [6:0] a);
		logic [7:0] d;
		d = 8'h00;
		case (a)
			ADDR_RX_LEN_HI: d = s.rx_len_hi;
			ADDR_RX_LEN_LO: d = s.rx_len_lo;
			ADDR_RX_SERVICE: d = s.rx_service;
			ADDR_TX_GAIN: d = s.tx_gain;
			ADDR_TX_DUR_HI: d = s.tx_dur_hi;
			ADDR_TX_DUR_LO: d = s.tx_dur_lo;
			ADDR_LOW_TRIM: d = s.low_trim & MASK_LOW_TRIM;
			ADDR_HIGH_TRIM: d = s.high_trim;
			ADDR_OPTIONS_A: d = s.options_a & MASK_OPTIONS_A;
			ADDR_OPTIONS_B: d = s.options_b & MASK_OPTIONS_B;
			default: d = 8'h00;
		endcase
		return d;
	endfunction : read_byte

	always_comb
	begin
		logic rise;
		logic fall;
		logic [7:0] wdata;
		logic [1:0] mag;
		logic wr_strobe;
		logic tx_go;
		logic us_tick;
		logic lna_fall;
		logic [15:0] dur;
		rise = 1'b0;
		fall = 1'b0;
		wdata = 8'h00;
		mag = 2'h0;
		wr_strobe = 1'b0;
		tx_go = 1'b0;
		us_tick = 1'b0;
		lna_fall = 1'b0;
		dur = 16'h0000;

		state_next = state_reg;
		rise = port_sclk && !state_reg.sclk_prev;
		fall = !port_sclk && state_reg.sclk_prev;
		state_next.sclk_prev = port_sclk;

		// Serial frame engine.
		if (port_sel_n)
		begin
			state_next.phase = BBM_PH_IDLE;
			state_next.bit_cnt = 5'h00;
			state_next.miso = 1'b0;
			state_next.read_op = 1'b0;
			state_next.shift_out = RESET_BYTE;
		end
		else
		begin
			case (state_reg.phase)
				BBM_PH_IDLE:
				begin
					state_next.phase = BBM_PH_ADDR;
					state_next.bit_cnt = 5'h00;
					if (rise)
					begin
						state_next.shift_in = {state_reg.shift_in[6:0], port_mosi};
						state_next.bit_cnt = 5'h01;
					end
				end
				BBM_PH_ADDR:
				begin
					if (rise)
					begin
						wdata = {state_reg.shift_in[6:0], port_mosi};
						state_next.shift_in = wdata;
						state_next.bit_cnt = state_reg.bit_cnt + 5'h01;
						if (state_reg.bit_cnt + 5'h01 == FRAME_ADDR_BITS)
						begin
							state_next.read_op = wdata[7];
							state_next.addr = wdata[6:0];
							state_next.shift_out = read_byte(state_reg, wdata[6:0]);
							state_next.phase = BBM_PH_DATA;
						end
					end
				end
				BBM_PH_DATA:
				begin
					if (fall)
					begin
						state_next.miso = state_reg.read_op && state_reg.bit_cnt != FRAME_BITS
							&& state_reg.shift_out[7];
						state_next.shift_out = {state_reg.shift_out[6:0], 1'b0};
					end
					if (rise && state_reg.bit_cnt != FRAME_BITS)
					begin
						wdata = {state_reg.shift_in[6:0], port_mosi};
						state_next.shift_in = wdata;
						state_next.bit_cnt = state_reg.bit_cnt + 5'h01;
						if (state_reg.bit_cnt + 5'h01 == FRAME_BITS && !state_reg.read_op)
						begin
							wr_strobe = 1'b1;
						end
					end
				end
				default:
				begin
					state_next.phase = BBM_PH_IDLE;
				end
			endcase
		end

		// Register write at the close of a write frame.
		if (wr_strobe)
		begin
			case (state_reg.addr)
				ADDR_TX_GAIN: state_next.tx_gain = wdata;
				ADDR_TX_DUR_HI: state_next.tx_dur_hi = wdata;
				ADDR_TX_DUR_LO: state_next.tx_dur_lo = wdata;
				ADDR_LOW_TRIM: state_next.low_trim = wdata & MASK_LOW_TRIM;
				ADDR_HIGH_TRIM: state_next.high_trim = wdata;
				ADDR_OPTIONS_A: state_next.options_a = wdata & MASK_OPTIONS_A;
				ADDR_OPTIONS_B: state_next.options_b = wdata & MASK_OPTIONS_B;
				default: state_next.addr = state_reg.addr;
			endcase
		end

		// Received header capture; the length is the packet time in microseconds.
		if (rx_header_valid)
		begin
			state_next.rx_len_hi = received_length_bits[15:8];
			state_next.rx_len_lo = received_length_bits[7:0];
			state_next.rx_service = received_service_bits;
		end

		// Transmit duration in microseconds; a request while busy is ignored.
		dur = {state_reg.tx_dur_hi, state_reg.tx_dur_lo};
		tx_go = tx_start && !state_reg.tx_busy;
		us_tick = state_reg.tx_busy && state_reg.us_div == US_DIV_LAST;
		if (tx_go)
		begin
			state_next.us_left = dur;
			state_next.us_div = 5'h00;
			state_next.tx_busy = dur != 16'h0000;
		end
		else if (state_reg.tx_busy)
		begin
			if (us_tick)
			begin
				state_next.us_div = 5'h00;
				state_next.us_left = state_reg.us_left - 16'h0001;
				if (state_reg.us_left == 16'h0001)
				begin
					state_next.tx_busy = 1'b0;
				end
			end
			else
			begin
				state_next.us_div = state_reg.us_div + 5'h01;
			end
		end

		// Saturation threshold from signed-magnitude offset.
		mag = state_next.options_a[OPA_SAT_MAG_MSB:OPA_SAT_MAG_LSB];
		if (state_next.options_a[OPA_SAT_SIGN_BIT])
		begin
			state_next.sat_thr = SAT_BASE - {1'b0, mag};
		end
		else
		begin
			state_next.sat_thr = SAT_BASE + {1'b0, mag};
		end

		// AGC decision hold after an LNA gain step down.
		state_next.lna_prev = lna_gain_select_pin;
		lna_fall = state_reg.lna_prev && !lna_gain_select_pin;
		if (lna_fall)
		begin
			if (state_reg.options_b[OPB_LNA_HOLD_BIT])
			begin
				state_next.hold_cnt = HOLD_TOTAL_CYC;
			end
			else
			begin
				state_next.hold_cnt = HOLD_BASE_CYC;
			end
		end
		else if (state_reg.hold_cnt != 6'h00)
		begin
			state_next.hold_cnt = state_reg.hold_cnt - 6'h01;
		end
		state_next.hold = state_next.hold_cnt != 6'h00;
	end

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			state_reg <= STATE_RESET;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	assign port_miso = state_reg.miso;
	assign tx_active = state_reg.tx_busy;
	assign transmit_gain_code = state_reg.tx_gain[7:TXG_CODE_LSB];
	assign scrambler_bypass = state_reg.tx_gain[TXG_SCRAMBLE_BIT];
	assign transmit_length_extension = state_reg.tx_gain[TXG_LEN_EXT_BIT];
	assign low_gain_offset = state_reg.low_trim[TRIM_MSB:0];
	assign high_gain_offset = state_reg.high_trim[TRIM_MSB:0];
	assign ch14_filter_enable = state_reg.high_trim[HGT_CH14_BIT];
	assign ds_attenuation_pad = state_reg.high_trim[HGT_PAD_BIT];
	assign saturation_threshold = state_reg.sat_thr;
	assign agc_retrigger_enable = state_reg.options_a[OPA_RETRIG_BIT];
	assign alt_data_bus_enable = state_reg.options_a[OPA_ALT_BUS_BIT];
	assign agc_retrigger_low = state_reg.options_b[OPB_RETRIG_LOW_BIT];
	assign agc_decision_hold = state_reg.hold;
endmodule : bbm_regs

// ==== bench/bbm_regs_chk.sv ====
// Purpose: Port checker for the modem control register bank.
// Assumes: Serial frames end with select high for several cycles.
// Notes: Bound to every instance of the register bank.
module bbm_regs_chk
(
	// Clock and reset.
	input wire logic core_clk,
	input wire logic sys_rst,
	// Serial control port.
	input wire logic port_sclk,
	input wire logic port_sel_n,
	input wire logic port_miso,
	// Transmit control.
	input wire logic tx_start,
	input wire logic tx_active,
	input wire logic [5:0] transmit_gain_code,
	input wire logic scrambler_bypass,
	input wire logic transmit_length_extension,
	// Calibration and options.
	input wire logic [5:0] low_gain_offset,
	input wire logic [5:0] high_gain_offset,
	input wire logic ch14_filter_enable,
	input wire logic ds_attenuation_pad,
	input wire logic lna_gain_select_pin,
	input wire logic [2:0] saturation_threshold,
	input wire logic agc_retrigger_enable,
	input wire logic alt_data_bus_enable,
	input wire logic agc_retrigger_low,
	input wire logic agc_decision_hold
);
	timeunit 1ns;
	timeprecision 100ps;
	int tx_run;
	int hold_run;
	logic lna_q;
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	// Lengths of the current high runs of the two timed outputs.
	always_ff @(posedge core_clk)
	begin
		tx_run <= (sys_rst || !tx_active) ? 0 : tx_run + 1;
		lna_q <= lna_gain_select_pin;
		hold_run <= (sys_rst || !agc_decision_hold || (lna_q && !lna_gain_select_pin)) ? 0
			: hold_run + 1;
	end
	rst_vals_a: assert property (disable iff (1'b0) sys_rst |=> saturation_threshold == 3'h4
		&& !tx_active && !agc_decision_hold && transmit_gain_code == 6'h00)
		else $error("Outputs not at reset values.");
	tx_len_a: assert property ($fell(tx_active) |-> tx_run % 25 == 0)
		else $error("Transmit time is not whole microseconds.");
	tx_cause_a: assert property ($rose(tx_active) |-> $past(tx_start))
		else $error("Transmit began without a request.");
	hold_start_a: assert property ($fell(lna_gain_select_pin) |=> agc_decision_hold)
		else $error("No hold after LNA select fall.");
	hold_len_a: assert property ($fell(agc_decision_hold) |-> hold_run == 25 || hold_run == 50)
		else $error("AGC hold of wrong length.");
	miso_move_a: assert property ($changed(port_miso) |-> $past(port_sel_n)
		|| !$past(port_sclk) && ($past(port_sclk, 2) || $past(port_sclk, 3)))
		else $error("Read data moved without a clock fall.");
	gain_quiet_a: assert property ($changed({transmit_gain_code, scrambler_bypass,
		transmit_length_extension}) |-> !port_sel_n)
		else $error("Transmit gain changed outside a frame.");
	opt_quiet_a: assert property ($changed({low_gain_offset, high_gain_offset,
		ch14_filter_enable, ds_attenuation_pad, saturation_threshold, agc_retrigger_enable,
		alt_data_bus_enable, agc_retrigger_low}) |-> !port_sel_n)
		else $error("Option outputs changed outside a frame.");
endmodule : bbm_regs_chk
bind bbm_regs bbm_regs_chk u_chk (
	.core_clk(core_clk),
	.sys_rst(sys_rst),
	.port_sclk(port_sclk),
	.port_sel_n(port_sel_n),
	.port_miso(port_miso),
	.tx_start(tx_start),
	.tx_active(tx_active),
	.transmit_gain_code(transmit_gain_code),
	.scrambler_bypass(scrambler_bypass),
	.transmit_length_extension(transmit_length_extension),
	.low_gain_offset(low_gain_offset),
	.high_gain_offset(high_gain_offset),
	.ch14_filter_enable(ch14_filter_enable),
	.ds_attenuation_pad(ds_attenuation_pad),
	.lna_gain_select_pin(lna_gain_select_pin),
	.saturation_threshold(saturation_threshold),
	.agc_retrigger_enable(agc_retrigger_enable),
	.alt_data_bus_enable(alt_data_bus_enable),
	.agc_retrigger_low(agc_retrigger_low),
	.agc_decision_hold(agc_decision_hold)
);

// ==== bench/bbm_host.sv ====
// Purpose: Host controller model driving the serial control port.
// Assumes: Read flag first, seven address bits, eight data bits, MSB first.
// Notes: The serial clock stands low between frames.
module bbm_host
(
	// Clock.
	input wire logic core_clk,
	// Serial control port.
	output logic port_sclk,
	output logic port_sel_n,
	output logic port_mosi,
	input wire logic port_miso
);
	timeunit 1ns;
	timeprecision 100ps;
	initial
	begin
		port_sclk = 0;
		port_sel_n = 1;
		port_mosi = 0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#2;
	endtask : tick
	// One whole frame; read data is taken at the rises of the data half.
	task automatic xfer(input logic rd, input logic [6:0] a, input logic [7:0] d,
		output logic [7:0] q);
		logic [15:0] f;
		f = {rd, a, d};
		port_sel_n = 0;
		for (int i = 15; i >= 0; i--)
		begin
			port_mosi = f[i];
			port_sclk = 0;
			tick(3);
			port_sclk = 1;
			if (i < 8)
				q[i] = port_miso;
			tick(2);
		end
		port_sclk = 0;
		port_mosi = ~port_mosi;
		tick(2);
		port_sel_n = 1;
		tick(3);
	endtask : xfer
	// A write frame cut short after n rises; the port must drop it.
	task automatic cut(input logic [6:0] a, input logic [7:0] d, input int n);
		logic [15:0] f;
		f = {1'b0, a, d};
		port_sel_n = 0;
		for (int i = 15; i > 15 - n; i--)
		begin
			port_mosi = f[i];
			port_sclk = 0;
			tick(3);
			port_sclk = 1;
			tick(2);
		end
		port_sclk = 0;
		tick(2);
		port_sel_n = 1;
		tick(3);
	endtask : cut
endmodule : bbm_host

// ==== bench/tb_top.sv ====
// Purpose: Self-checking bench for the modem control register bank.
// Assumes: Register model starts at zero and tracks every write.
// Notes: Random data comes from a fixed-seed shift register.
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic core_clk = 0;
	logic sys_rst, rx_header_valid, tx_start, lna_gain_select_pin;
	logic [15:0] received_length_bits;
	logic [7:0] received_service_bits;
	logic port_sclk, port_sel_n, port_mosi, port_miso;
	logic tx_active, scrambler_bypass, transmit_length_extension, ch14_filter_enable;
	logic ds_attenuation_pad, agc_retrigger_enable, alt_data_bus_enable, agc_retrigger_low;
	logic agc_decision_hold;
	logic [5:0] transmit_gain_code, low_gain_offset, high_gain_offset;
	logic [2:0] saturation_threshold;
	logic [31:0] lf = 32'h99102477;
	logic [7:0] q;
	int mem[32];
	int err_total, comparisons, cyc, n;
	bbm_regs dut (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.port_sclk(port_sclk),
		.port_sel_n(port_sel_n),
		.port_mosi(port_mosi),
		.port_miso(port_miso),
		.rx_header_valid(rx_header_valid),
		.received_length_bits(received_length_bits),
		.received_service_bits(received_service_bits),
		.tx_start(tx_start),
		.tx_active(tx_active),
		.transmit_gain_code(transmit_gain_code),
		.scrambler_bypass(scrambler_bypass),
		.transmit_length_extension(transmit_length_extension),
		.low_gain_offset(low_gain_offset),
		.high_gain_offset(high_gain_offset),
		.ch14_filter_enable(ch14_filter_enable),
		.ds_attenuation_pad(ds_attenuation_pad),
		.lna_gain_select_pin(lna_gain_select_pin),
		.saturation_threshold(saturation_threshold),
		.agc_retrigger_enable(agc_retrigger_enable),
		.alt_data_bus_enable(alt_data_bus_enable),
		.agc_retrigger_low(agc_retrigger_low),
		.agc_decision_hold(agc_decision_hold)
	);
	bbm_host host (
		.core_clk(core_clk),
		.port_sclk(port_sclk),
		.port_sel_n(port_sel_n),
		.port_mosi(port_mosi),
		.port_miso(port_miso)
	);
	always #20 core_clk = ~core_clk;
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task automatic stop_test();
		$display("Counts: comparisons=%0d err_total=%0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : stop_test
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// Writes one register, updates the model and checks every setting output.
	task automatic wr(input int a, input int d);
		int m;
		if (a == 28 || a == 29)
			d = d & (a == 28 ? 8'hF8 : 8'h84);
		host.xfer(1'b0, 7'(a), 8'(d), q);
		case (a)
			7'h11, 7'h12, 7'h13, 7'h15, 7'h1C, 7'h1D: mem[a] = d;
			7'h14: mem[a] = d & 8'h3F;
			default: ;
		endcase
		m = (mem[28] >> 5) & 3;
		chk({transmit_gain_code, scrambler_bypass, transmit_length_extension}, 16'(mem[17]));
		chk(16'(low_gain_offset), 16'(mem[20]));
		chk({ch14_filter_enable, ds_attenuation_pad, high_gain_offset}, 16'(mem[21]));
		chk(16'(saturation_threshold), 16'(mem[28][7] ? 4 - m : 4 + m));
		chk({agc_retrigger_enable, alt_data_bus_enable, agc_retrigger_low},
			{mem[28][4], mem[28][3], mem[29][2]});
	endtask : wr
	task automatic rd_all();
		for (int a = 5; a < 32; a++)
		begin
			host.xfer(1'b1, 7'(a), 8'h00, q);
			chk(16'(q), 16'(mem[a]));
		end
	endtask : rd_all
	// Counts the high cycles of the transmit or the hold output.
	task automatic run_len(input int which, output int k);
		k = 0;
		for (int i = 0; i < 3000; i++)
		begin
			@(posedge core_clk);
			#2;
			tx_start = (i == 5 && which == 0);
			if ((which ? agc_decision_hold : tx_active) !== 1'b1)
				break;
			k++;
		end
	endtask : run_len
	always @(posedge core_clk)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			err_total++;
			stop_test();
		end
	end
	initial
	begin
		sys_rst = 1;
		rx_header_valid = 0;
		received_length_bits = 16'h0000;
		received_service_bits = 8'h00;
		tx_start = 0;
		lna_gain_select_pin = 1;
		repeat (12) @(posedge core_clk);
		#2;
		sys_rst = 0;
		rd_all();
		lf = lfsr(lf);
		received_length_bits = lf[15:0];
		received_service_bits = lf[23:16];
		rx_header_valid = 1;
		mem[5] = lf[15:8];
		mem[6] = lf[7:0];
		mem[7] = lf[23:16];
		host.tick(1);
		rx_header_valid = 0;
		received_length_bits = ~received_length_bits;
		received_service_bits = ~received_service_bits;
		for (int i = 0; i < 40; i++)
		begin
			lf = lfsr(lf);
			wr(5 + lf[12:8] % 27, lf[7:0]);
		end
		host.cut(7'h15, 8'(~mem[21]), 15);
		wr(17, lf[7:0]);
		rd_all();
		wr(18, 0);
		wr(19, int'(lf[1:0]) + 1);
		tx_start = 1;
		run_len(0, n);
		chk(16'(n), 16'(mem[19] * 25));
		for (int k = 0; k < 2; k++)
		begin
			wr(29, k * 128 + 4);
			lna_gain_select_pin = 0;
			run_len(1, n);
			lna_gain_select_pin = 1;
			chk(16'(n), 16'(25 + k * 25));
		end
		stop_test();
	end
endmodule : tb_top
